// File: hdl/fpec_ctrl.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps

// Contract
// RULE1 - Sector select pair picks erase sectors and shows sector and bank status.
// RULE2 - While erasing, hardware drives the bank status bit for bank zero.
// RULE3 - Bank status bit clears itself when erase ends without error.
// RULE4 - Sector status bits set during erase, cleared at clean end.
// RULE5 - With error flag one, set status bits mean erase error there.
// RULE6 - Error zero, suspend one: set bits mean suspended; both zero: no meaning.
// RULE7 - Software loads target address and data pairs before programming.
// RULE8 - Word program uses first data pair, double word both; start launches.
// RULE9 - Erase select with sector pair as operands, started by start bit.
// RULE10 - Protection select with value in first data pair, started by start bit.
// RULE11 - Suspend bit alone suspends; no operands and no start bit.
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter int unsigned ERASE_LEN = ERASE_CYCLES
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash array side
  input  wire logic        erase_fail,
  output fpec_prog_s       prog,
  output logic             prog_strobe,
  output logic [31:0]      prot_value,
  output logic             prot_strobe,
  output logic             erase_run,
  output logic [5:0]       erase_sectors,
  // Interrupt
  output logic             irq
);

  fpec_regs_s  r;
  fpec_regs_s  next_r;
  logic        tmr_load;
  logic [31:0] tmr_count;
  logic        tmr_done;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // True when the address hits the given register index
  function automatic logic hit_idx(input logic [31:0] a, input logic [19:0] idx);
    hit_idx = (a[31:22] == 10'h000) && (a[21:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // True when exactly one operation select is set
  function automatic logic one_sel(input logic [3:0] s);
    one_sel = (s == 4'h1) || (s == 4'h2) || (s == 4'h4) || (s == 4'h8);
  endfunction

  // Read value of a register, hit flag in bit 32
  function automatic logic [32:0] read_reg(input logic [31:0] a, input fpec_regs_s s);
    logic [15:0] v;
    logic        h;
    v = ZERO16;
    h = 1'b1;
    if (hit_idx(a, IDX_CTRL)) begin
      v[CTL_W-1:0] = s.ctrl;
      v[CTL_BUSY]  = (s.state != ST_IDLE);
    end else if (hit_idx(a, IDX_SECT_LO)) begin
      v[SECT_NUM-1:0] = s.sect;
    end else if (hit_idx(a, IDX_SECT_HI)) begin
      v[HI_B0S] = s.b0s;
    end else if (hit_idx(a, IDX_D0_LO)) begin
      v = s.d0_lo;
    end else if (hit_idx(a, IDX_D0_HI)) begin
      v = s.d0_hi;
    end else if (hit_idx(a, IDX_D1_LO)) begin
      v = s.d1_lo;
    end else if (hit_idx(a, IDX_D1_HI)) begin
      v = s.d1_hi;
    end else if (hit_idx(a, IDX_ADR_LO)) begin
      v = s.adr_lo;
    end else if (hit_idx(a, IDX_ADR_HI)) begin
      v = s.adr_hi;
    end else if (hit_idx(a, IDX_FLAGS)) begin
      v[FLG_ERR]  = s.err;
      v[FLG_SUSPEND_REQUEST_BIT] = s.suspend_request_bit;
    end else if (hit_idx(a, IDX_IRQ_ST)) begin
      v[IRQ_W-1:0] = s.irq_st;
    end else if (hit_idx(a, IDX_IRQ_MSK)) begin
      v[IRQ_W-1:0] = s.irq_msk;
    end else begin
      h = 1'b0;
    end
    read_reg = {h, ZERO16, v};
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Bus answer, register writes, operation sequencing and interrupt
  always_comb begin
    logic        acc;
    logic        wr;
    logic [32:0] rv;
    logic [3:0]  sel;
    logic [IRQ_W-1:0] ev;
    next_r             = r;
    acc                = psel && penable;
    wr                 = acc && r.pready && pwrite && !r.pslverr;
    rv                 = read_reg(paddr, r);
    sel                = pwdata[CTL_SPR:CTL_WPG];
    ev                 = IRQ_RST;
    tmr_load           = 1'b0;
    tmr_count          = 32'h0000_0000;
    next_r.pready      = 1'b0;
    next_r.pslverr     = 1'b0;
    next_r.prog_strobe = 1'b0;
    next_r.prot_strobe = 1'b0;

    // One wait state, then answer; unmapped address gives an error
    if (acc && !r.pready) begin
      next_r.pready  = 1'b1;
      next_r.pslverr = !rv[32];
      next_r.prdata  = rv[32] ? rv[31:0] : 32'h0000_0000;
    end

    // Register writes take effect on the completing edge
    if (wr) begin
      if (hit_idx(paddr, IDX_CTRL)) begin
        if (r.state == ST_IDLE) begin
          next_r.ctrl = {1'b0, 1'b0, sel};
          if (pwdata[CTL_WMS] && one_sel(sel)) begin
            next_r.ctrl[CTL_WMS] = 1'b1;
            next_r.state         = ST_RUN;
            next_r.fail          = 1'b0;
            tmr_load             = 1'b1;
            if (sel[CTL_SER]) begin
              // Sector pair is the erase operand and becomes the status  [RULE9] [RULE1]
              next_r.b0s       = 1'b1;                                    // [RULE2]
              next_r.erase_run = 1'b1;                                    // [RULE4]
              next_r.err       = 1'b0;
              tmr_count        = ERASE_LEN;
            end else if (sel[CTL_SPR]) begin
              tmr_count = PROT_CYCLES;                                    // [RULE10]
            end else begin
              // Address pair with one or both data pairs                 [RULE7] [RULE8]
              next_r.prog.addr   = {r.adr_hi, r.adr_lo};
              next_r.prog.data   = sel[CTL_DOUBLE_WORD_PROGRAM_SELECT] ? {r.d1_hi, r.d1_lo, r.d0_hi, r.d0_lo}
                                                 : {DATA_RST, DATA_RST, r.d0_hi, r.d0_lo};
              next_r.prog.dbl    = sel[CTL_DOUBLE_WORD_PROGRAM_SELECT];
              next_r.prog_strobe = 1'b1;
              tmr_count          = PROG_CYCLES;
            end
          end
        end else if (pwdata[CTL_SUSPEND_REQUEST_BIT] && r.state == ST_RUN && !tmr_done) begin
          // Suspend needs no operands and no start bit                    [RULE11]
          next_r.state          = ST_SUSPEND_REQUEST_BIT;
          next_r.ctrl[CTL_SUSPEND_REQUEST_BIT] = 1'b1;
          next_r.suspend_request_bit           = 1'b1;                                   // [RULE6]
          ev[IRQ_SUSPEND_REQUEST_BIT]          = 1'b1;
        end else if (!pwdata[CTL_SUSPEND_REQUEST_BIT] && r.state == ST_SUSPEND_REQUEST_BIT) begin
          // Clearing the suspend bit resumes the operation
          next_r.state          = ST_RUN;
          next_r.ctrl[CTL_SUSPEND_REQUEST_BIT] = 1'b0;
          next_r.suspend_request_bit           = 1'b0;
        end
      end else if (r.state == ST_IDLE) begin
        // Operand registers are frozen while an operation runs
        if (hit_idx(paddr, IDX_SECT_LO)) begin
          next_r.sect = pwdata[SECT_NUM-1:0];                             // [RULE1]
        end
        if (hit_idx(paddr, IDX_D0_LO)) begin
          next_r.d0_lo = pwdata[15:0];
        end
        if (hit_idx(paddr, IDX_D0_HI)) begin
          next_r.d0_hi = pwdata[15:0];
        end
        if (hit_idx(paddr, IDX_D1_LO)) begin
          next_r.d1_lo = pwdata[15:0];
        end
        if (hit_idx(paddr, IDX_D1_HI)) begin
          next_r.d1_hi = pwdata[15:0];
        end
        if (hit_idx(paddr, IDX_ADR_LO)) begin
          next_r.adr_lo = pwdata[15:0];
        end
        if (hit_idx(paddr, IDX_ADR_HI)) begin
          next_r.adr_hi = pwdata[15:0];
        end
      end
      // Write one to clear the error flag and status, mask written directly; hardware sets below win
      if (hit_idx(paddr, IDX_FLAGS)) begin
        next_r.err = r.err & ~pwdata[FLG_ERR];
      end
      if (hit_idx(paddr, IDX_IRQ_ST)) begin
        next_r.irq_st = r.irq_st & ~pwdata[IRQ_W-1:0];
      end
      if (hit_idx(paddr, IDX_IRQ_MSK)) begin
        next_r.irq_msk = pwdata[IRQ_W-1:0];
      end
    end

    // Operation sequencing
    case (r.state)
      ST_IDLE: begin
      end
      ST_RUN: begin
        if (r.ctrl[CTL_SER] && erase_fail) begin
          next_r.fail = 1'b1;
        end
        if (tmr_done) begin
          next_r.state = ST_IDLE;
          next_r.ctrl  = '0;
          ev[IRQ_DONE] = 1'b1;
          if (r.ctrl[CTL_SER]) begin
            next_r.erase_run = 1'b0;
            if (r.fail || erase_fail) begin
              // Status bits stay set and mean erase error                 [RULE5]
              next_r.err   = 1'b1;
              ev[IRQ_ERR]  = 1'b1;
            end else begin
              next_r.b0s  = 1'b0;                                         // [RULE3]
              next_r.sect = SECT_RST;                                     // [RULE4]
            end
          end
          if (r.ctrl[CTL_SPR]) begin
            next_r.prot_value  = {r.d0_hi, r.d0_lo};                      // [RULE10]
            next_r.prot_strobe = 1'b1;
          end
        end
      end
      ST_SUSPEND_REQUEST_BIT: begin
        // Bank and sector bits held set, read as suspended                [RULE6]
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Sticky interrupt status, set wins over clear
    next_r.irq_st = next_r.irq_st | ev;
    next_r.irq    = |(next_r.irq_st & next_r.irq_msk);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  // All state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.state   <= ST_IDLE;
      r.d0_lo   <= DATA_RST;
      r.d0_hi   <= DATA_RST;
      r.d1_lo   <= DATA_RST;
      r.d1_hi   <= DATA_RST;
      r.sect    <= SECT_RST;
      r.irq_st  <= IRQ_RST;
      r.irq_msk <= IRQ_RST;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Operation timer
  // ---------------------------------------------------------------

  // Duration of the running operation, frozen while suspended
  fpec_op_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tmr_load),
    .count   (tmr_count),
    .hold    (r.state == ST_SUSPEND_REQUEST_BIT),
    .done    (tmr_done),
    .busy    ()
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign prog          = r.prog;
  assign prog_strobe   = r.prog_strobe;
  assign prot_value    = r.prot_value;
  assign prot_strobe   = r.prot_strobe;
  assign erase_run     = r.erase_run;
  assign erase_sectors = r.sect;
  assign irq           = r.irq;

endmodule

// File: hdl/fpec_pkg.sv
package fpec_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [19:0] IDX_CTRL     = 20'h80000;
  localparam logic [19:0] IDX_SECT_LO  = 20'h80004;
  localparam logic [19:0] IDX_SECT_HI  = 20'h80006;
  localparam logic [19:0] IDX_D0_LO    = 20'h80008;
  localparam logic [19:0] IDX_D0_HI    = 20'h8000A;
  localparam logic [19:0] IDX_D1_LO    = 20'h8000C;
  localparam logic [19:0] IDX_D1_HI    = 20'h8000E;
  localparam logic [19:0] IDX_ADR_LO   = 20'h80010;
  localparam logic [19:0] IDX_ADR_HI   = 20'h80012;
  localparam logic [19:0] IDX_FLAGS    = 20'h80014;
  localparam logic [19:0] IDX_IRQ_ST   = 20'h80016;
  localparam logic [19:0] IDX_IRQ_MSK  = 20'h80018;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_WPG   = 0;  // Single word program select
  localparam int CTL_DOUBLE_WORD_PROGRAM_SELECT  = 1;  // Double word program select
  localparam int CTL_SER   = 2;  // Sector erase select
  localparam int CTL_SPR   = 3;  // Protection set select
  localparam int CTL_SUSPEND_REQUEST_BIT  = 4;  // Suspend request
  localparam int CTL_WMS   = 5;  // Operation start
  localparam int CTL_BUSY  = 6;  // Operation in progress (read only)
  localparam int CTL_W     = 6;
  localparam int SECT_NUM  = 6;  // Sectors of bank zero
  localparam int HI_B0S    = 8;  // Bank zero status bit position
  localparam int FLG_ERR   = 0;
  localparam int FLG_SUSPEND_REQUEST_BIT  = 1;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_SUSPEND_REQUEST_BIT  = 2;
  localparam int IRQ_W     = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0]       DATA_RST = 16'hFFFF;
  localparam logic [15:0]       ZERO16   = 16'h0000;
  localparam logic [SECT_NUM-1:0] SECT_RST = 6'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 50;
  localparam int PROG_TIME_US    = 20;
  localparam int PROT_TIME_US    = 20;
  localparam int ERASE_TIME_US   = 1000;
  localparam int PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
  localparam int PROT_CYCLES     = PROT_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES    = ERASE_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_SUSPEND_REQUEST_BIT
  } fpec_state_e;

  // Program request towards the array
  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] data;
    logic        dbl;
  } fpec_prog_s;

  // Timer state
  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
    logic        done;
  } fpec_tmr_s;

  // Sequencer and register state
  typedef struct packed {
    fpec_state_e         state;
    logic [CTL_W-1:0]    ctrl;
    logic [SECT_NUM-1:0] sect;
    logic                b0s;
    logic [15:0]         d0_lo;
    logic [15:0]         d0_hi;
    logic [15:0]         d1_lo;
    logic [15:0]         d1_hi;
    logic [15:0]         adr_lo;
    logic [15:0]         adr_hi;
    logic                err;
    logic                suspend_request_bit;
    logic                fail;
    logic [IRQ_W-1:0]    irq_st;
    logic [IRQ_W-1:0]    irq_msk;
    logic                irq;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    fpec_prog_s          prog;
    logic                prog_strobe;
    logic [31:0]         prot_value;
    logic                prot_strobe;
    logic                erase_run;
  } fpec_regs_s;

endpackage

// File: hdl/fpec_op_timer.sv
`timescale 1ns/100ps

// Counts the duration of one operation; holds while suspended
module fpec_op_timer
  import fpec_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        load,
  input  wire logic [31:0] count,
  input  wire logic        hold,
  // Status
  output logic             done,
  output logic             busy
);

  fpec_tmr_s r;
  fpec_tmr_s next_r;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------

  // Load starts a count, done pulses for one cycle at the end
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (load) begin
      next_r.cnt  = (count == 32'h0000_0000) ? 32'h0000_0001 : count;
      next_r.busy = 1'b1;
    end else if (r.busy && !hold) begin
      if (r.cnt == 32'h0000_0001) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      next_r.cnt = r.cnt - 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign busy = r.busy;

endmodule

// File: tb/fpec_chk.sv
`timescale 1ns/100ps

// Port-level checks of the program and erase controller
module fpec_chk
  import fpec_pkg::*;
#(
  parameter int unsigned ERASE_LEN = 20
)
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Register bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Array side
  input wire logic       erase_fail,
  input wire logic       prog_strobe,
  input wire logic       prot_strobe,
  input wire logic       erase_run,
  input wire logic [5:0] erase_sectors
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [31:0] run_cnt;
  logic        fail_seen;

  // Length of the current erase and whether the array flagged it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt   <= '0;
      fail_seen <= 1'b0;
    end else if (!erase_run) begin
      run_cnt   <= '0;
      fail_seen <= 1'b0;
    end else begin
      run_cnt   <= run_cnt + 32'h1;
      fail_seen <= fail_seen | erase_fail;
    end
  end

  AST_READY_WAIT: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready outside an access");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_PROG_GAP: assert property (prog_strobe |=> !prog_strobe [*8])
    else $error("program strobes too close");
  AST_PROT_PULSE: assert property (prot_strobe |=> !prot_strobe && !erase_run)
    else $error("protection strobe malformed");
  AST_SECT_HOLD: assert property (erase_run && $past(erase_run) |-> $stable(erase_sectors))
    else $error("sector bits moved during erase");
  AST_ERASE_LEN: assert property ($fell(erase_run) |-> run_cnt >= ERASE_LEN - 1)
    else $error("erase ended early");
  AST_CLEAN_END: assert property ($fell(erase_run) && !fail_seen |-> ##[0:1] erase_sectors == 6'h00)
    else $error("sector bits kept after clean erase");
  AST_FAIL_KEEP: assert property ($fell(erase_run) && fail_seen |-> erase_sectors == $past(erase_sectors))
    else $error("sector bits lost after failed erase");

  // Main scenarios reached
  cover property (prog_strobe);
  cover property (prot_strobe);
  cover property ($fell(erase_run) && fail_seen);
  cover property ($fell(erase_run) && !fail_seen);
endmodule

// File: tb/fpec_flash_model.sv
`timescale 1ns/100ps

// Behavioural flash array facing the controller
module fpec_flash_model
  import fpec_pkg::*;
#(
  parameter int FAIL_DLY = 3
)
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Requests from the controller
  input wire logic        erase_run,
  input wire logic        prog_strobe,
  input wire fpec_prog_s  prog,
  input wire logic        prot_strobe,
  input wire logic [31:0] prot_value,
  // Scenario control
  input wire logic        fail_mode,
  // Answers and capture
  output logic            erase_fail,
  output fpec_prog_s      last_prog,
  output logic [31:0]     last_prot
);
  logic [3:0] dly;

  // Late error report in erase, captures of program and protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly        <= '0;
      erase_fail <= 1'b0;
      last_prog  <= '0;
      last_prot  <= '0;
    end else begin
      dly        <= erase_run ? dly + {3'h0, dly != 4'hF} : 4'h0;
      erase_fail <= erase_run && fail_mode && (dly >= FAIL_DLY);
      if (prog_strobe) last_prog <= prog;
      if (prot_strobe) last_prot <= prot_value;
    end
  end
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps

// Self-checking bench of the program and erase controller
module tb;
  import fpec_pkg::*;
  localparam int unsigned ERASE_LEN = 40;

  logic        pclk, presetn, psel, penable, pwrite, fail_mode, err;
  logic        pready, pslverr, prog_strobe, prot_strobe, erase_run, erase_fail, irq;
  logic [31:0] paddr, pwdata, prdata, prot_value, last_prot, rd;
  logic [5:0]  erase_sectors;
  fpec_prog_s  prog, last_prog;
  int          n_errors, cmp_count;

  fpec_ctrl #(.ERASE_LEN(ERASE_LEN)) u_fpec_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .erase_fail(erase_fail), .prog(prog), .prog_strobe(prog_strobe), .prot_value(prot_value),
    .prot_strobe(prot_strobe), .erase_run(erase_run), .erase_sectors(erase_sectors), .irq(irq));

  fpec_flash_model u_fpec_flash_model (
    .pclk(pclk), .presetn(presetn), .erase_run(erase_run), .prog_strobe(prog_strobe),
    .prog(prog), .prot_strobe(prot_strobe), .prot_value(prot_value), .fail_mode(fail_mode),
    .erase_fail(erase_fail), .last_prog(last_prog), .last_prot(last_prot));

  // Clock generation
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer, then one idle edge
  task automatic apb(input logic [19:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {10'h000, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'hDEAD, 32'h0);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    apb(idx, 1'b1, d);
  endtask

  task automatic rdc(input logic [19:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic busy_is(input logic [31:0] exp);
    apb(IDX_CTRL, 1'b0, 32'h0);
    chk(rd & 32'h40, exp);
  endtask

  // Poll the busy bit until the operation ends
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(IDX_CTRL, 1'b0, 32'h0);
      n++;
    end while (rd[CTL_BUSY] !== 1'b0 && n < 600);
    chk(rd & 32'h40, 32'h0);
  endtask

  task automatic t_regs();
    rdc(IDX_SECT_HI, 32'h0000);
    rdc(IDX_D0_LO, 32'hFFFF);
    apb(20'h80030, 1'b1, 32'h1234);
    chk({31'h0, err}, 32'h1);
    wr(IDX_SECT_HI, 32'h0100);
    rdc(IDX_SECT_HI, 32'h0000);
    $display("test regs done");
  endtask

  task automatic t_word();
    wr(IDX_ADR_LO, 32'h5678);
    wr(IDX_ADR_HI, 32'h0001);
    wr(IDX_D0_LO, 32'hBEEF);
    wr(IDX_D0_HI, 32'hDEAD);
    wr(IDX_D1_LO, 32'h1111);
    wr(IDX_CTRL, 32'h21);
    busy_is(32'h40);
    wr(IDX_D0_LO, 32'h0000);
    rdc(IDX_D0_LO, 32'hBEEF);
    wait_idle();
    chk(last_prog.addr, 32'h00015678);
    chk(last_prog.data[63:32], 32'hFFFFFFFF);
    chk(last_prog.data[31:0], 32'hDEADBEEF);
    chk({31'h0, last_prog.dbl}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_ST, 32'h1);
    wr(IDX_IRQ_MSK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_ST, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test word program done");
  endtask

  task automatic t_dbl();
    wr(IDX_CTRL, 32'h23);
    busy_is(32'h0);
    wr(IDX_CTRL, 32'h00);
    wr(IDX_D1_HI, 32'h2222);
    wr(IDX_CTRL, 32'h22);
    wait_idle();
    chk(last_prog.data[63:32], 32'h22221111);
    chk({31'h0, last_prog.dbl}, 32'h1);
    wr(IDX_IRQ_ST, 32'h7);
    $display("test double program done");
  endtask

  task automatic start_erase(input logic [31:0] s);
    wr(IDX_SECT_LO, s);
    wr(IDX_CTRL, 32'h24);
    rdc(IDX_SECT_HI, 32'h0100);
    rdc(IDX_SECT_LO, s);
  endtask

  task automatic t_erase_ok();
    start_erase(32'h2D);
    wait_idle();
    rdc(IDX_SECT_HI, 32'h0000);
    rdc(IDX_SECT_LO, 32'h0000);
    rdc(IDX_FLAGS, 32'h0);
    wr(IDX_IRQ_ST, 32'h7);
    $display("test clean erase done");
  endtask

  task automatic t_erase_fail();
    fail_mode <= 1'b1;
    start_erase(32'h12);
    wait_idle();
    rdc(IDX_FLAGS, 32'h1);
    rdc(IDX_SECT_HI, 32'h0100);
    rdc(IDX_SECT_LO, 32'h12);
    rdc(IDX_IRQ_ST, 32'h3);
    wr(IDX_FLAGS, 32'h1);
    rdc(IDX_FLAGS, 32'h0);
    wr(IDX_IRQ_ST, 32'h7);
    fail_mode <= 1'b0;
    $display("test failed erase done");
  endtask

  task automatic t_suspend();
    start_erase(32'h01);
    wr(IDX_CTRL, 32'h10);
    rdc(IDX_FLAGS, 32'h2);
    repeat (ERASE_LEN + 10) @(posedge pclk);
    busy_is(32'h40);
    rdc(IDX_SECT_HI, 32'h0100);
    rdc(IDX_IRQ_ST, 32'h4);
    wr(IDX_CTRL, 32'h00);
    wait_idle();
    rdc(IDX_FLAGS, 32'h0);
    rdc(IDX_SECT_HI, 32'h0000);
    wr(IDX_IRQ_ST, 32'h7);
    $display("test suspend done");
  endtask

  task automatic t_prot();
    wr(IDX_D0_LO, 32'h00AA);
    wr(IDX_D0_HI, 32'h5500);
    wr(IDX_CTRL, 32'h28);
    wait_idle();
    chk(last_prot, 32'h550000AA);
    $display("test protection done");
  endtask

  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    fail_mode = 1'b0;
    presetn = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_word();
    t_dbl();
    t_erase_ok();
    t_erase_fail();
    t_suspend();
    t_prot();
    end_of_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end
endmodule

bind fpec_ctrl fpec_chk #(.ERASE_LEN(ERASE_LEN)) u_fpec_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .erase_fail(erase_fail), .prog_strobe(prog_strobe),
  .prot_strobe(prot_strobe), .erase_run(erase_run), .erase_sectors(erase_sectors));
